// [pkg/ldd_host_pkg.sv]
// Package: constants, states and pin bundle of the LED chain host
package ldd_host_pkg;

  // ****************************************************************
  // Register map (AXI4-Lite byte addresses)
  // ****************************************************************
  localparam logic [4:0] ADDR_CMD    = 5'h00;
  localparam logic [4:0] ADDR_TX     = 5'h04;
  localparam logic [4:0] ADDR_RX     = 5'h08;
  localparam logic [4:0] ADDR_STATUS = 5'h0c;
  localparam logic [4:0] ADDR_ONTIME = 5'h10;

  // ****************************************************************
  // Fields and values
  // ****************************************************************
  localparam int          CMD_OP_LSB  = 0;
  localparam int          CMD_CNT_LSB = 2;
  localparam int          CMD_WAKE    = 5;
  localparam logic [1:0]  OP_SHIFT    = 2'h0;
  localparam logic [1:0]  OP_MODE     = 2'h1;
  localparam logic [1:0]  OP_SHOW     = 2'h2;
  localparam logic [2:0]  CNT_LOWCUR  = 3'h3;
  localparam logic [2:0]  CNT_SHUT    = 3'h4;
  localparam logic [2:0]  PULSE_ARM   = 3'h2;
  localparam int          ST_BUSY     = 0;
  localparam int          ST_FLAG     = 1;
  localparam int          ST_ARMED    = 2;
  localparam int          ST_VALID    = 3;
  localparam logic [31:0] ONTIME_RST  = 32'h0000_0014;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_DECERR = 2'h3;
  localparam int          BITS_PER_DEV = 8;

  // ****************************************************************
  // Timing: half period of the shift clock
  // ****************************************************************
  localparam int SYS_CLK_NS  = 10;
  localparam int HALF_BIT_NS = 50;
  localparam int HALF_BIT_CY = (HALF_BIT_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0000,
    ST_SH_LO  = 4'b0001,
    ST_SH_HI  = 4'b0010,
    ST_LD_HI  = 4'b0011,
    ST_LD_LO  = 4'b0100,
    ST_EM_LD  = 4'b0101,
    ST_EM_LO  = 4'b0110,
    ST_EM_HI  = 4'b0111,
    ST_EM_END = 4'b1000,
    ST_OE_ON  = 4'b1001,
    ST_OE_OFF = 4'b1010
  } ldd_state_t;

  typedef struct packed {
    logic serial_in;
    logic shift_clk;
    logic load_strobe;
    logic output_enable_n;
  } ldd_pins_t;

endpackage : ldd_host_pkg

// [logic/ldd_host.sv]
// Host controller for a chain of serial LED drivers with diagnostics
//
// Contract
// RULE1: Detailed report is only marked valid after a global error mode run.
// RULE2: Driver copies the selected report to its shift register at strobe fall.
// RULE3: Report shifts out with eight clocks per cascaded driver.
// RULE4: New data shifted during read-out loads on the next strobe rise.
// RULE5: Loaded data shows on the outputs when output enable falls.
// RULE6: Temperature report carries each chip's flag in bit 0.
// RULE7: Temperature flag zero marks over-temperature, one is normal.
// RULE8: Open-LED bit is zero only for a lit channel found open.
// RULE9: Shorted-LED report clears shorted channel bits, healthy ones stay one.
// RULE10: Cascade report is one continuous stream without gaps.
// RULE11: Host loads a pattern lighting every channel to be tested.
// RULE12: Host should enter low-current mode before an open-LED test.
// RULE13: Host should enter low-current mode before a shorted-LED test.
// RULE14: Three pulses in error-detection mode select low-current mode.
// RULE15: After strobe fall in low-current mode host may shift all ones.
// RULE16: In low-current mode next enable fall reduces sink current.
// RULE17: Next enable rise restores current; report then readable.
// RULE18: Four pulses in error-detection mode select shutdown or wakeup.
// RULE19: For shutdown host drives serial input low after third pulse rise.
// RULE20: For wakeup host drives serial input high after third pulse.
// RULE21: Driver samples the shutdown bit at the fourth pulse rise.
// RULE22: Each driver passes the shutdown bit down the chain.
// RULE23: Error mode starts at strobe rise with enable high and clock low.
// RULE24: Pulse count selects temperature, open, short, low-current, shutdown.
// RULE25: Driver captures error status at the enable rise.
// RULE26: Data shifts in on clock rise, most significant bit first.
// RULE27: Report leaves in entry order, farthest driver's word first.
`timescale 1ns/1ps

module ldd_host #(
  parameter int N_DEV    = 4,
  parameter int HALF_DIV = ldd_host_pkg::HALF_BIT_CY
) (
  input  wire logic                   clk_sys,
  input  wire logic                   rstn,
  input  wire logic [4:0]             s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [4:0]             s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  output ldd_host_pkg::ldd_pins_t     pins,
  input  wire logic                   serial_out
);

  localparam int NBITS = N_DEV * ldd_host_pkg::BITS_PER_DEV;

  // ****************************************************************
  // Pin input synchroniser
  // ****************************************************************
  logic so_meta;
  logic so_sync;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      so_meta <= 1'b1;
      so_sync <= 1'b1;
    end
    else
    begin
      so_meta <= serial_out;
      so_sync <= so_meta;
    end
  end

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  logic        aw_held;
  logic        w_held;
  logic [4:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic [1:0]  op;
  logic [2:0]  pulses;
  logic        wake;
  logic [31:0] tx_data;
  logic [31:0] rx_data;
  logic [31:0] on_time;
  logic        busy;
  logic        flag;
  logic        armed;
  logic        rx_valid;
  logic        start;

  wire aw_hs   = s_axi_awvalid && s_axi_awready;
  wire w_hs    = s_axi_wvalid && s_axi_wready;
  wire do_wr   = aw_held && w_held && !s_axi_bvalid;
  wire hit_cmd = aw_addr == ldd_host_pkg::ADDR_CMD;
  wire hit_tx  = aw_addr == ldd_host_pkg::ADDR_TX;
  wire hit_on  = aw_addr == ldd_host_pkg::ADDR_ONTIME;
  wire hit_rx  = aw_addr == ldd_host_pkg::ADDR_RX;
  wire hit_st  = aw_addr == ldd_host_pkg::ADDR_STATUS;
  wire wr_ok   = hit_cmd || hit_tx || hit_on || hit_rx || hit_st;
  // Commands written while a sequence runs are dropped, never queued
  wire cmd_go  = do_wr && hit_cmd && w_strb[0] && !busy;

  wire [31:0] status_word = {28'h0000000, rx_valid, armed, flag, busy};
  wire        rd_cmd = s_axi_araddr == ldd_host_pkg::ADDR_CMD;
  wire        rd_tx  = s_axi_araddr == ldd_host_pkg::ADDR_TX;
  wire        rd_rx  = s_axi_araddr == ldd_host_pkg::ADDR_RX;
  wire        rd_st  = s_axi_araddr == ldd_host_pkg::ADDR_STATUS;
  wire        rd_on  = s_axi_araddr == ldd_host_pkg::ADDR_ONTIME;
  wire        rd_ok  = rd_cmd || rd_tx || rd_rx || rd_st || rd_on;
  wire [31:0] rd_mux = rd_cmd ? {26'h0000000, wake, pulses, op} :
                       rd_tx  ? tx_data :
                       rd_rx  ? rx_data :
                       rd_st  ? status_word :
                       rd_on  ? on_time : 32'h0000_0000;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 5'h00;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= ldd_host_pkg::RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= ldd_host_pkg::RESP_OKAY;
    end
    else
    begin
      if (aw_hs)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (w_hs)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_wr)
      begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? ldd_host_pkg::RESP_OKAY
                              : ldd_host_pkg::RESP_DECERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= rd_ok ? ldd_host_pkg::RESP_OKAY
                              : ldd_host_pkg::RESP_DECERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // Byte-lane writes of the two data words
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_lane
      always_ff @(posedge clk_sys or negedge rstn)
      begin
        if (!rstn)
        begin
          tx_data[gi*8 +: 8] <= 8'h00;
          on_time[gi*8 +: 8] <= ldd_host_pkg::ONTIME_RST[gi*8 +: 8];
        end
        else if (do_wr && w_strb[gi])
        begin
          if (hit_tx)
            tx_data[gi*8 +: 8] <= w_data[gi*8 +: 8];
          if (hit_on)
            on_time[gi*8 +: 8] <= w_data[gi*8 +: 8];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      op     <= ldd_host_pkg::OP_SHIFT;
      pulses <= 3'h0;
      wake   <= 1'b1;
      start  <= 1'b0;
    end
    else
    begin
      start <= cmd_go;
      if (cmd_go)
      begin
        op     <= w_data[ldd_host_pkg::CMD_OP_LSB +: 2];
        pulses <= w_data[ldd_host_pkg::CMD_CNT_LSB +: 3];
        wake   <= w_data[ldd_host_pkg::CMD_WAKE];
      end
    end
  end

  // ****************************************************************
  // Half-bit divider
  // ****************************************************************
  logic [15:0] div_cnt;
  wire         tick = div_cnt == 16'(HALF_DIV - 1);

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      div_cnt <= 16'h0000;
    else if (tick || start)
      div_cnt <= 16'h0000;
    else
      div_cnt <= div_cnt + 16'h0001;
  end

  // ****************************************************************
  // Pin sequencer
  // ****************************************************************
  ldd_host_pkg::ldd_state_t state;
  logic [5:0]  bit_idx;
  logic [2:0]  pulse_cnt;
  logic [31:0] on_cnt;
  logic [31:0] tx_shift;

  wire last_bit  = bit_idx == 6'(NBITS - 1);
  wire pulses_ok = pulse_cnt == pulses;
  wire on_done   = on_cnt >= on_time;

  assign busy = state != ldd_host_pkg::ST_IDLE || start;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      state     <= ldd_host_pkg::ST_IDLE;
      pins      <= '{serial_in: 1'b1, shift_clk: 1'b0,
                     load_strobe: 1'b0, output_enable_n: 1'b1};
      bit_idx   <= 6'h00;
      pulse_cnt <= 3'h0;
      on_cnt    <= 32'h0000_0000;
      tx_shift  <= 32'h0000_0000;
      rx_data   <= 32'h0000_0000;
      flag      <= 1'b1;
      armed     <= 1'b0;
      rx_valid  <= 1'b0;
    end
    else
    begin
      case (state)
        ldd_host_pkg::ST_IDLE:
          if (start)
          begin
            bit_idx   <= 6'h00;
            pulse_cnt <= 3'h0;
            on_cnt    <= 32'h0000_0000;
            if (op == ldd_host_pkg::OP_SHIFT)
            begin
              // Pattern from software; all ones for a full test
              tx_shift       <= tx_data << (32 - NBITS); // RULE11 RULE15
              pins.serial_in <= tx_data[NBITS-1]; // RULE26
              state          <= ldd_host_pkg::ST_SH_LO;
            end
            else if (op == ldd_host_pkg::OP_MODE)
            begin
              pins.shift_clk <= 1'b0; // RULE23
              pins.serial_in <= 1'b1;
              state          <= ldd_host_pkg::ST_EM_LD; // RULE12 RULE13
            end
            else if (op == ldd_host_pkg::OP_SHOW)
            begin
              pins.output_enable_n <= 1'b0; // RULE5 RULE16
              state                <= ldd_host_pkg::ST_OE_ON;
            end
          end
        ldd_host_pkg::ST_SH_LO:
          if (tick)
          begin
            pins.shift_clk <= 1'b1; // RULE26
            // Stream arrives gap-free, farthest word first
            rx_data <= {rx_data[30:0], so_sync}; // RULE3 RULE10 RULE27
            state   <= ldd_host_pkg::ST_SH_HI;
          end
        ldd_host_pkg::ST_SH_HI:
          if (tick)
          begin
            pins.shift_clk <= 1'b0;
            if (last_bit) // RULE3
            begin
              pins.load_strobe <= 1'b1; // RULE4
              state            <= ldd_host_pkg::ST_LD_HI;
            end
            else
            begin
              bit_idx        <= bit_idx + 6'h01;
              tx_shift       <= {tx_shift[30:0], 1'b0};
              pins.serial_in <= tx_shift[30];
              state          <= ldd_host_pkg::ST_SH_LO;
            end
          end
        ldd_host_pkg::ST_LD_HI:
          if (tick)
          begin
            pins.load_strobe <= 1'b0;
            // Captured bits are a report only after a temperature, open or short test selection
            rx_valid <= armed; // RULE1
            armed    <= 1'b0;
            state    <= ldd_host_pkg::ST_LD_LO;
          end
        ldd_host_pkg::ST_LD_LO:
          if (tick)
            state <= ldd_host_pkg::ST_IDLE;
        ldd_host_pkg::ST_EM_LD:
          if (tick)
          begin
            pins.load_strobe <= 1'b1; // RULE23
            state            <= ldd_host_pkg::ST_EM_LO;
          end
        ldd_host_pkg::ST_EM_LO:
          if (tick)
          begin
            if (pulses_ok) // RULE24 RULE14 RULE18
            begin
              // Global flag: zero means some driver reported a fault
              flag             <= so_sync; // RULE7
              pins.load_strobe <= 1'b0; // RULE2
              state            <= ldd_host_pkg::ST_EM_END;
            end
            else
            begin
              pins.shift_clk <= 1'b1; // RULE21
              state          <= ldd_host_pkg::ST_EM_HI;
            end
          end
        ldd_host_pkg::ST_EM_HI:
          if (tick)
          begin
            pins.shift_clk <= 1'b0;
            pulse_cnt      <= pulse_cnt + 3'h1;
            if (pulse_cnt == ldd_host_pkg::PULSE_ARM)
              pins.serial_in <= wake; // RULE19 RULE20
            state <= ldd_host_pkg::ST_EM_LO;
          end
        ldd_host_pkg::ST_EM_END:
          if (tick)
          begin
            pins.serial_in <= 1'b1;
            // Only test selections leave a report to read
            armed <= pulses < ldd_host_pkg::CNT_LOWCUR; // RULE1
            state <= ldd_host_pkg::ST_IDLE;
          end
        ldd_host_pkg::ST_OE_ON:
          if (tick)
          begin
            if (on_done)
            begin
              pins.output_enable_n <= 1'b1; // RULE17 RULE25
              state                <= ldd_host_pkg::ST_OE_OFF;
            end
            else
              on_cnt <= on_cnt + 32'h0000_0001;
          end
        ldd_host_pkg::ST_OE_OFF:
          if (tick)
            state <= ldd_host_pkg::ST_IDLE;
        default:
          state <= ldd_host_pkg::ST_IDLE;
      endcase
    end
  end

endmodule : ldd_host

// [testbench/ldd_host_sva.sv]
// Checker: pin sequencing and bus answers of the LED chain host
`timescale 1ns/1ps

module ldd_host_sva #(
  parameter int N_DEV    = 4,
  parameter int HALF_DIV = 5
) (
  input wire logic                    clk_sys,
  input wire logic                    rstn,
  input wire logic                    s_axi_arvalid,
  input wire logic                    s_axi_arready,
  input wire logic                    s_axi_rvalid,
  input wire logic                    s_axi_bvalid,
  input wire logic                    s_axi_bready,
  input wire logic [1:0]              s_axi_bresp,
  input wire ldd_host_pkg::ldd_pins_t pins
);
  // ****************************************************************
  // Helpers and properties
  // ****************************************************************
  logic [7:0] clk_run;
  logic [7:0] pulse_cnt;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  // Starts full so the first clock edge after reset is never short
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
      clk_run <= 8'hff;
    else if ($changed(pins.shift_clk))
      clk_run <= 8'h01;
    else if (clk_run != 8'hff)
      clk_run <= clk_run + 8'h01;

  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
      pulse_cnt <= 8'h00;
    else if ($rose(pins.load_strobe))
      pulse_cnt <= 8'h00;
    else if ($rose(pins.shift_clk) && pins.load_strobe)
      pulse_cnt <= pulse_cnt + 8'h01;

  property p_ld_clk_low;
    $rose(pins.load_strobe) |-> !pins.shift_clk;
  endproperty
  a_ld_clk_low: assert property (p_ld_clk_low)
    else $error("strobe rose with shift clock high");
  property p_ld_oen_high;
    $rose(pins.load_strobe) |-> pins.output_enable_n;
  endproperty
  a_ld_oen_high: assert property (p_ld_oen_high)
    else $error("strobe rose with outputs enabled");
  property p_oen_quiet;
    !pins.output_enable_n |-> !pins.load_strobe && !pins.shift_clk;
  endproperty
  a_oen_quiet: assert property (p_oen_quiet)
    else $error("strobe or clock active while outputs enabled");
  property p_clk_stands;
    $changed(pins.shift_clk) |-> clk_run >= HALF_DIV;
  endproperty
  a_clk_stands: assert property (p_clk_stands)
    else $error("shift clock phase shorter than half period");
  property p_si_steady;
    pins.shift_clk |-> $stable(pins.serial_in);
  endproperty
  a_si_steady: assert property (p_si_steady)
    else $error("serial input moved while shift clock high");
  property p_pulse_max;
    $fell(pins.load_strobe) |-> pulse_cnt <= 8'h04;
  endproperty
  a_pulse_max: assert property (p_pulse_max)
    else $error("more than four mode pulses");
  property p_rd_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read answer late");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped before taken");
endmodule : ldd_host_sva

bind ldd_host ldd_host_sva #(.N_DEV(N_DEV), .HALF_DIV(HALF_DIV)) u_sva (
  .clk_sys(clk_sys), .rstn(rstn), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .pins(pins));

// [testbench/ldd_chain_model.sv]
// Behavioural chain of LED drivers as seen at the host pins
`timescale 1ns/1ps

module ldd_chain_model #(
  parameter int N_DEV = 4
) (
  input  wire ldd_host_pkg::ldd_pins_t pins,
  output logic                         serial_out,
  output logic                         reduced_test_current,
  input  wire logic [N_DEV-1:0]        hot,
  input  wire logic [N_DEV*8-1:0]      open_m,
  input  wire logic [N_DEV*8-1:0]      short_m
);
  // ****************************************************************
  // Chain state
  // ****************************************************************
  localparam int NB = N_DEV * 8;
  logic [NB-1:0] sr = '1;
  logic [NB-1:0] data_q = '0;
  logic [NB-1:0] outs = '0;
  logic [NB-1:0] op_st = '1;
  logic [NB-1:0] sh_st = '1;
  logic [NB-1:0] tmp_w = '1;
  logic          em = 1'h0;
  logic          fresh = 1'h0;
  logic          low_arm = 1'h0;
  logic          shut = 1'h0;
  logic          saw_low = 1'h0;
  logic [2:0]    pulses = 3'h0;

  // Flag gated down the chain; needs a one at the first serial input
  assign serial_out = em ? pins.serial_in &
                      (&(pulses == 3'h0 ? tmp_w : pulses == 3'h1 ? op_st
                      : sh_st)) : sr[NB-1];

  always @(posedge pins.shift_clk)
    if (em)
    begin
      pulses <= pulses + 3'h1;
      if (pulses == 3'h3)
        shut <= ~pins.serial_in;
    end
    else
    begin
      sr <= {sr[NB-2:0], pins.serial_in};
      fresh <= 1'h1;
    end

  // Only freshly shifted data reaches the display register
  always @(posedge pins.load_strobe)
  begin
    if (fresh)
      data_q <= sr;
    fresh <= 1'h0;
    if (pins.output_enable_n && !pins.shift_clk)
      em <= 1'h1;
    pulses <= 3'h0;
  end

  always @(negedge pins.load_strobe)
  begin
    em <= 1'h0;
    if (em === 1'h1)
      case (pulses)
        3'h0: sr <= tmp_w;
        3'h1: sr <= op_st;
        3'h2: sr <= sh_st;
        3'h3: low_arm <= 1'h1;
        default: ;
      endcase
  end

  always @(negedge pins.output_enable_n)
  begin
    outs <= data_q;
    reduced_test_current <= low_arm;
    saw_low <= saw_low | low_arm;
  end

  always @(posedge pins.output_enable_n)
  begin
    for (int k = 0; k < N_DEV; k++)
      tmp_w[8*k+:8] <= {7'h7f, ~hot[k]};
    op_st <= ~(outs & open_m);
    sh_st <= ~(outs & short_m);
    reduced_test_current <= 1'h0;
    low_arm <= 1'h0;
  end
endmodule : ldd_chain_model

// [testbench/testbench.sv]
// Self-checking bench for the LED chain host
`timescale 1ns/1ps

module testbench;
  // ****************************************************************
  // Signals, tasks and sequence
  // ****************************************************************
  localparam int ND = 4;
  logic                    clk_sys = 1'h0;
  logic                    rstn = 1'h0;
  logic [4:0]              awaddr = 5'h00;
  logic [4:0]              araddr = 5'h00;
  logic [31:0]             wdata = 32'h0;
  logic                    awvalid = 1'h0;
  logic                    wvalid = 1'h0;
  logic                    bready = 1'h0;
  logic                    arvalid = 1'h0;
  logic                    rready = 1'h0;
  logic                    awready, wready, bvalid, arready, rvalid;
  logic                    serial_out, low_i;
  logic [1:0]              bresp, rresp, resp;
  logic [31:0]             rdata, rd;
  ldd_host_pkg::ldd_pins_t pins;
  logic [ND-1:0]           hot = '0;
  logic [ND*8-1:0]         open_m = '0;
  logic [ND*8-1:0]         short_m = '0;
  int                      mismatches = 0;
  int                      check_count = 0;

  always #5 clk_sys = ~clk_sys;

  ldd_host #(.N_DEV(ND), .HALF_DIV(5)) u_dut (
    .clk_sys(clk_sys), .rstn(rstn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pins(pins), .serial_out(serial_out));

  ldd_chain_model #(.N_DEV(ND)) u_dev (
    .pins(pins), .serial_out(serial_out), .reduced_test_current(low_i),
    .hot(hot), .open_m(open_m), .short_m(short_m));

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up

  task automatic hang;
    mismatches++;
    wrap_up();
  endtask : hang

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Handshakes are judged at the falling edge, acted on at the next rise
  task automatic axi_wr(input logic [4:0] a, input logic [31:0] d);
    int   n;
    logic ah, wh, bh;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    bh = 1'h0;
    for (n = 0; n < 100 && !bh; n++)
    begin
      @(negedge clk_sys);
      ah = awvalid && awready;
      wh = wvalid && wready;
      bh = bvalid;
      resp = bresp;
      @(posedge clk_sys);
      if (ah)
        awvalid <= 1'h0;
      if (wh)
        wvalid <= 1'h0;
    end
    bready <= 1'h0;
    if (!bh)
      hang();
  endtask : axi_wr

  task automatic axi_rd(input logic [4:0] a);
    int   n;
    logic ah, h;
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    h = 1'h0;
    for (n = 0; n < 100 && !h; n++)
    begin
      @(negedge clk_sys);
      ah = arvalid && arready;
      h = rvalid;
      rd = rdata;
      resp = rresp;
      @(posedge clk_sys);
      if (ah)
        arvalid <= 1'h0;
    end
    rready <= 1'h0;
    if (!h)
      hang();
  endtask : axi_rd

  task automatic run(input logic [31:0] c);
    int n;
    axi_wr(ldd_host_pkg::ADDR_CMD, c);
    rd = 32'h1;
    for (n = 0; n < 500 && rd[ldd_host_pkg::ST_BUSY] !== 1'h0; n++)
      axi_rd(ldd_host_pkg::ADDR_STATUS);
    if (rd[ldd_host_pkg::ST_BUSY] !== 1'h0)
      hang();
  endtask : run

  function automatic logic [31:0] mode(input logic [2:0] p, input logic w);
    return {26'h0, w, p, ldd_host_pkg::OP_MODE};
  endfunction : mode

  task automatic diag(input logic [2:0] p, input logic [31:0] pat,
                      input logic [31:0] msk, input logic [31:0] exp,
                      input logic lc);
    axi_wr(ldd_host_pkg::ADDR_TX, pat);
    run({30'h0, ldd_host_pkg::OP_SHIFT});
    chk(u_dev.data_q, pat);
    if (lc)
      run(mode(ldd_host_pkg::CNT_LOWCUR, 1'h1));
    run({30'h0, ldd_host_pkg::OP_SHOW});
    chk(u_dev.outs, pat);
    chk({31'h0, low_i}, 32'h0);
    chk({31'h0, u_dev.saw_low}, {31'h0, lc});
    run(mode(p, 1'h1));
    axi_rd(ldd_host_pkg::ADDR_STATUS);
    chk({31'h0, rd[ldd_host_pkg::ST_FLAG]}, {31'h0, &(exp | ~msk)});
    axi_wr(ldd_host_pkg::ADDR_TX, ~pat);
    run({30'h0, ldd_host_pkg::OP_SHIFT});
    chk(u_dev.data_q, ~pat);
    axi_rd(ldd_host_pkg::ADDR_RX);
    chk(rd & msk, exp & msk);
    axi_rd(ldd_host_pkg::ADDR_STATUS);
    chk({31'h0, rd[ldd_host_pkg::ST_VALID]}, 32'h1);
  endtask : diag

  initial
  begin
    repeat (4) @(posedge clk_sys);
    rstn <= 1'h1;
    axi_rd(ldd_host_pkg::ADDR_ONTIME);
    chk(rd, ldd_host_pkg::ONTIME_RST);
    axi_rd(ldd_host_pkg::ADDR_STATUS);
    chk(rd & 32'hd, 32'h0);
    axi_rd(5'h1c);
    chk({30'h0, resp}, {30'h0, ldd_host_pkg::RESP_DECERR});
    axi_wr(5'h18, 32'h0);
    chk({30'h0, resp}, {30'h0, ldd_host_pkg::RESP_DECERR});
    axi_wr(ldd_host_pkg::ADDR_ONTIME, 32'h3);
    hot <= 4'h4;
    diag(3'h0, '1, 32'h0101_0101, 32'h0100_0101, 1'h0);
    hot <= 4'h0;
    diag(3'h0, '1, 32'h0101_0101, 32'h0101_0101, 1'h0);
    open_m <= 32'h0018_0041;
    diag(3'h1, 32'hffff_fff0, 32'hffff_fff0, 32'hffe7_ffbf, 1'h1);
    open_m <= 32'h0;
    short_m <= 32'h0600_0010;
    diag(3'h2, '1, '1, 32'hf9ff_ffef, 1'h1);
    for (int w = 0; w < 2; w++)
    begin
      run(mode(ldd_host_pkg::CNT_SHUT, w[0]));
      chk({31'h0, u_dev.shut}, {31'h0, ~w[0]});
      axi_rd(ldd_host_pkg::ADDR_CMD);
      chk(rd, mode(ldd_host_pkg::CNT_SHUT, w[0]));
    end
    wrap_up();
  end
endmodule : testbench
